//--- hdl/acc_pkg.sv
// Package: register map, fields, states and timing for the conversion controller
// Notes on behaviour
// - Extended sample mode with asynchronous clock may corrupt results; pulse or sync avoids.
// - A trigger arriving while busy halts all later conversions until recovery.
// - Halt applies to sequence, repeat-single and repeat-sequence modes.
// - Conversions start by software start bit or by timer trigger.
// - Timer overflow flag is unreliable; it never reports the overlap.
// - Clear enable and power, set power then enable, restart; conversions resume.
// - Leaving subsystem clock while gated off hangs converter at dividers /3, /5, /7.
// - The clock-switch hang clears only through system reset.
package acc_pkg;

  localparam logic [3:0] ACC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] ACC_OFS_CLK    = 4'h4;
  localparam logic [3:0] ACC_OFS_STATUS = 4'h8;
  localparam logic [3:0] ACC_OFS_IRQ    = 4'hC;
  localparam logic [3:0] ACC_OFS_MASK   = 4'h8 + 4'h6;
  localparam logic [3:0] ACC_OFS_RESULT = 4'h1;

  // Control register bits
  localparam int ACC_CTRL_SC   = 0;
  localparam int ACC_CTRL_ENC  = 1;
  localparam int ACC_CTRL_ON   = 2;
  localparam int ACC_CTRL_SHP  = 3;
  localparam int ACC_CTRL_TSRC = 4;
  localparam int ACC_CTRL_SEQ  = 5;
  localparam int ACC_CTRL_SHP_PULSE = 7;

  // Clock register fields
  localparam int ACC_CLK_SEL = 0;
  localparam int ACC_CLK_DIV = 2;
  localparam int ACC_CLK_GOFF = 5;

  // Interrupt bits
  localparam int ACC_IRQ_DONE = 0;
  localparam int ACC_IRQ_OVL  = 1;
  localparam int ACC_IRQ_TOV  = 2;
  localparam int ACC_IRQ_W    = 3;

  localparam logic [1:0] ACC_SEL_SUBSYS = 2'b11;
  localparam logic [1:0] ACC_SEQ_SINGLE = 2'b00;

  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [7:0] ACC_CLK_RST  = 8'h00;

  // Sample and conversion times in ns at a 4 ns clock
  localparam int ACC_CLK_PERIOD_NS = 4;
  localparam int ACC_SAMPLE_NS     = 64;
  localparam int ACC_CONV_NS       = 48;
  localparam int ACC_SAMPLE_CYC    = (ACC_SAMPLE_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;
  localparam int ACC_CONV_CYC      = (ACC_CONV_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;
  localparam int ACC_CHANNELS      = 4;

  typedef enum logic [1:0] {
    ACC_ST_IDLE   = 2'b00,
    ACC_ST_SAMPLE = 2'b01,
    ACC_ST_CONV   = 2'b10,
    ACC_ST_HALT   = 2'b11
  } acc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acc_bus_req_t;

endpackage : acc_pkg

//--- hdl/acc_clkdiv.sv
// Conversion clock divider producing a tick, with the clock-switch hang latch
`timescale 1ns/10ps
module acc_clkdiv
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] clk_sel_i,
  input  wire logic [2:0] clk_div_i,
  input  wire logic       gate_off_i,
  output logic            tick_o,
  output logic            hung_o
);

  logic [2:0] cnt_q;
  logic [1:0] sel_q;
  logic       hung_q;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || hung_q)
      cnt_q <= 3'h0;
    else if (cnt_q >= clk_div_i)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_q + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      sel_q <= 2'b00;
    else
      sel_q <= clk_sel_i;
  end

  // Divide value is N-1: odd dividers /3 /5 /7 are codes 2, 4, 6
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      hung_q <= 1'b0;
    else if (sel_q == acc_pkg::ACC_SEL_SUBSYS && clk_sel_i != acc_pkg::ACC_SEL_SUBSYS
             && gate_off_i && clk_div_i[0] == 1'b0 && clk_div_i != 3'h0)
      hung_q <= 1'b1;
  end

  assign tick_o = !hung_q && (cnt_q >= clk_div_i);
  assign hung_o = hung_q;

endmodule : acc_clkdiv

//--- hdl/acc_ctrl.sv
// Conversion control top: registers, trigger handling, sequencer, halt and interrupts
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
module acc_ctrl
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       timer_trig_i,
  input  wire logic       async_clk_i,
  input  wire logic [7:0] analog_i,
  output logic            busy_o,
  output logic            halted_o,
  output logic            irq_o
);

  logic [7:0]             ctrl_q;
  logic [7:0]             clk_q;
  logic [acc_pkg::ACC_IRQ_W-1:0] stat_q;
  logic [acc_pkg::ACC_IRQ_W-1:0] mask_q;
  logic [7:0]             result_q;
  logic [7:0]             rdata_q;
  logic [1:0]             trig_sync_q;
  logic                   trig_prev_q;
  logic [1:0]             async_sync_q;
  acc_pkg::acc_state_t    state_q;
  logic [7:0]             cnt_q;
  logic [1:0]             chan_q;
  logic                   stuck_q;
  logic                   tick;
  logic                   hung;
  logic                   trig_edge;
  logic                   sw_start;
  logic                   trigger;
  logic                   busy;
  logic                   done;
  logic                   enc;
  logic                   on;
  logic [1:0]             seq;
  logic                   bad_mode;

  assign enc = ctrl_q[acc_pkg::ACC_CTRL_ENC];
  assign on  = ctrl_q[acc_pkg::ACC_CTRL_ON];
  assign seq = ctrl_q[acc_pkg::ACC_CTRL_SEQ +: 2];

  acc_clkdiv u_div
  (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_sel_i  (clk_q[acc_pkg::ACC_CLK_SEL +: 2]),
    .clk_div_i  (clk_q[acc_pkg::ACC_CLK_DIV +: 3]),
    .gate_off_i (clk_q[acc_pkg::ACC_CLK_GOFF]),
    .tick_o     (tick),
    .hung_o     (hung)
  );

  // Timer trigger and async clock pins pass two flops; analog_i is not synchronised
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      trig_sync_q  <= 2'b00;
      async_sync_q <= 2'b00;
      trig_prev_q  <= 1'b0;
    end
    else
    begin
      trig_sync_q  <= {trig_sync_q[0], timer_trig_i};
      async_sync_q <= {async_sync_q[0], async_clk_i};
      trig_prev_q  <= trig_sync_q[1];
    end
  end

  // Start bit obeys the enable and power bits written with it
  assign sw_start  = wr_i && addr_i == acc_pkg::ACC_OFS_CTRL && wdata_i[acc_pkg::ACC_CTRL_SC]
                     && wdata_i[acc_pkg::ACC_CTRL_ENC] && wdata_i[acc_pkg::ACC_CTRL_ON];
  assign trig_edge = trig_sync_q[1] && !trig_prev_q && ctrl_q[acc_pkg::ACC_CTRL_TSRC];
  assign trigger   = sw_start || (enc && on && trig_edge);
  assign busy      = state_q == acc_pkg::ACC_ST_SAMPLE || state_q == acc_pkg::ACC_ST_CONV;
  assign done      = state_q == acc_pkg::ACC_ST_CONV && tick
                     && cnt_q == 8'(acc_pkg::ACC_CONV_CYC - 1);
  // Extended sample with asynchronous clock corrupts the result
  assign bad_mode  = !ctrl_q[acc_pkg::ACC_CTRL_SHP_PULSE] && async_sync_q[1];

  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ctrl_q <= acc_pkg::ACC_CTRL_RST;
    else if (wr_i && addr_i == acc_pkg::ACC_OFS_CTRL)
      ctrl_q <= {wdata_i[7:1], 1'b0} | {7'h00, 1'b0};
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      clk_q <= acc_pkg::ACC_CLK_RST;
    else if (wr_i && addr_i == acc_pkg::ACC_OFS_CLK)
      clk_q <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      mask_q <= '0;
    else if (wr_i && addr_i == acc_pkg::ACC_OFS_MASK)
      mask_q <= wdata_i[acc_pkg::ACC_IRQ_W-1:0];
  end

  // Halt latch: overlap in sequence modes, cleared when power and enable are both off
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      stuck_q <= 1'b0;
    else if (!on && !enc)
      stuck_q <= 1'b0;
    else if (trigger && busy && seq != acc_pkg::ACC_SEQ_SINGLE)
      stuck_q <= 1'b1;
  end

  // Sequencer
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || (!on && !sw_start))
    begin
      state_q <= acc_pkg::ACC_ST_IDLE;
      cnt_q   <= 8'h00;
      chan_q  <= 2'b00;
    end
    else
    begin
      case (state_q)
        acc_pkg::ACC_ST_IDLE:
        begin
          if (stuck_q || hung)
            state_q <= acc_pkg::ACC_ST_HALT;
          else if (trigger)
          begin
            state_q <= acc_pkg::ACC_ST_SAMPLE;
            cnt_q   <= 8'h00;
          end
        end
        acc_pkg::ACC_ST_SAMPLE:
        begin
          if (stuck_q || hung)
            state_q <= acc_pkg::ACC_ST_HALT;
          else if (tick && cnt_q == 8'(acc_pkg::ACC_SAMPLE_CYC - 1))
          begin
            state_q <= acc_pkg::ACC_ST_CONV;
            cnt_q   <= 8'h00;
          end
          else if (tick)
            cnt_q <= cnt_q + 8'h01;
        end
        acc_pkg::ACC_ST_CONV:
        begin
          if (stuck_q || hung)
            state_q <= acc_pkg::ACC_ST_HALT;
          else if (done)
          begin
            cnt_q <= 8'h00;
            if (seq[0] && chan_q != 2'(acc_pkg::ACC_CHANNELS - 1))
            begin
              chan_q  <= chan_q + 2'b01;
              state_q <= acc_pkg::ACC_ST_SAMPLE;
            end
            else
            begin
              chan_q  <= 2'b00;
              state_q <= seq[1] && enc ? acc_pkg::ACC_ST_SAMPLE : acc_pkg::ACC_ST_IDLE;
            end
          end
          else if (tick)
            cnt_q <= cnt_q + 8'h01;
        end
        acc_pkg::ACC_ST_HALT:
        begin
          if (!stuck_q && !hung)
            state_q <= acc_pkg::ACC_ST_IDLE;
        end
        default:
          state_q <= acc_pkg::ACC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      result_q <= 8'h00;
    else if (done)
      result_q <= bad_mode ? ~analog_i : analog_i;
  end

  // Status: set wins over read-clear; timer overflow flag never sets
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      stat_q <= '0;
    else
    begin
      stat_q[acc_pkg::ACC_IRQ_DONE] <= done ||
        (stat_q[acc_pkg::ACC_IRQ_DONE] && !(rd_i && addr_i == acc_pkg::ACC_OFS_IRQ));
      stat_q[acc_pkg::ACC_IRQ_OVL]  <= (trigger && busy) ||
        (stat_q[acc_pkg::ACC_IRQ_OVL] && !(rd_i && addr_i == acc_pkg::ACC_OFS_IRQ));
      stat_q[acc_pkg::ACC_IRQ_TOV]  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_q <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        acc_pkg::ACC_OFS_CTRL:   rdata_q <= ctrl_q;
        acc_pkg::ACC_OFS_CLK:    rdata_q <= clk_q;
        acc_pkg::ACC_OFS_STATUS: rdata_q <= {5'h00, hung, stuck_q, busy};
        acc_pkg::ACC_OFS_IRQ:    rdata_q <= {5'h00, stat_q};
        acc_pkg::ACC_OFS_MASK:   rdata_q <= {5'h00, mask_q};
        acc_pkg::ACC_OFS_RESULT: rdata_q <= result_q;
        default:                 rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign rdata_o  = rdata_q;
  assign busy_o   = busy;
  assign halted_o = state_q == acc_pkg::ACC_ST_HALT;
  assign irq_o    = |(stat_q & mask_q);

endmodule : acc_ctrl

//--- bench/acc_ctrl_checker.sv
// Port-level assertions for the conversion controller
`timescale 1ns/10ps
module acc_ctrl_checker
(
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       timer_trig_i,
  input wire logic       async_clk_i,
  input wire logic [7:0] analog_i,
  input wire logic       busy_o,
  input wire logic       halted_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic       ctl_wr;
  logic       go;
  logic [7:0] ctrl_q;
  assign ctl_wr = wr_i && (addr_i == acc_pkg::ACC_OFS_CTRL);
  assign go = wdata_i[acc_pkg::ACC_CTRL_ENC] && wdata_i[acc_pkg::ACC_CTRL_ON];
  // Last control value written
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ctrl_q <= 8'h00;
    else if (ctl_wr)
      ctrl_q <= wdata_i;
  end
  chk_reset_clean: assert property ($fell(sys_rst_i) |-> !busy_o && !halted_o && !irq_o)
    else $error("Outputs not idle after reset");
  chk_start_busy: assert property (ctl_wr && wdata_i[0] && go && !busy_o && !halted_o
    |-> ##[1:4] busy_o)
    else $error("Start not taken");
  chk_start_refused: assert property (ctl_wr && !go && !busy_o |=> !busy_o ##1 !busy_o)
    else $error("Start taken while disabled");
  chk_busy_min: assert property ($rose(busy_o) |-> busy_o[*8])
    else $error("Busy dropped early");
  chk_halt_hold: assert property (halted_o && !wr_i && !$past(wr_i) |=> halted_o)
    else $error("Halt left without a write");
  chk_halt_recover: assert property (halted_o && ctl_wr && !go |-> ##[1:2] !halted_o)
    else $error("Halt not cleared by disable");
  chk_halt_mode: assert property ($rose(halted_o) && $past(busy_o)
    |-> ctrl_q[6:5] != acc_pkg::ACC_SEQ_SINGLE)
    else $error("Halt in single mode");
  chk_timer_start: assert property ($rose(timer_trig_i) && ctrl_q[4] && ctrl_q[1] && ctrl_q[2]
    && !busy_o && !halted_o |-> ##[1:8] busy_o)
    else $error("Timer trigger not taken");
endmodule : acc_ctrl_checker

//--- bench/acc_ctrl_tb.sv
// Self-checking bench for the conversion controller
`timescale 1ns/10ps
module acc_ctrl_tb;
  localparam logic [3:0] CT = acc_pkg::ACC_OFS_CTRL;
  localparam logic [3:0] CK = acc_pkg::ACC_OFS_CLK;
  localparam logic [3:0] ST = acc_pkg::ACC_OFS_STATUS;
  localparam logic [3:0] IQ = acc_pkg::ACC_OFS_IRQ;
  localparam logic [3:0] MK = acc_pkg::ACC_OFS_MASK;
  localparam logic [3:0] RS = acc_pkg::ACC_OFS_RESULT;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       timer_trig_i = 1'b0;
  logic       async_clk_i = 1'b0;
  logic [7:0] analog_i = 8'h5A;
  logic [7:0] rdata_o;
  logic       busy_o;
  logic       halted_o;
  logic       irq_o;
  logic [3:0] ofs [7] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'hE, 4'h1, 4'h3};
  int         error_cnt = 0;
  int         compares = 0;
  acc_ctrl acc_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_trig_i(timer_trig_i),
    .async_clk_i(async_clk_i), .analog_i(analog_i), .busy_o(busy_o), .halted_o(halted_o),
    .irq_o(irq_o));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : rd
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_o !== lvl && n < 2000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (busy_o !== lvl)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask : wait_busy
  task automatic conv(input logic [7:0] c, input logic [7:0] exp);
    wr(CT, c);
    wait_busy(1'b1);
    rd(ST, 8'h01);
    wait_busy(1'b0);
    rd(RS, exp);
  endtask : conv
  initial
  begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(MK, 8'h01);
    wr(CT, 8'h03);
    wr(CT, 8'h05);
    conv(8'h87, 8'h5A);
    check({7'h0, irq_o}, 8'h01);
    wr(MK, 8'h00);
    rd(ST, 8'h00);
    check({7'h0, irq_o}, 8'h00);
    rd(IQ, 8'h01);
    rd(IQ, 8'h00);
    @(posedge clk_i);
    async_clk_i <= 1'b1;
    conv(8'h87, 8'h5A);
    conv(8'h07, 8'hA5);
    @(posedge clk_i);
    async_clk_i <= 1'b0;
    conv(8'h07, 8'h5A);
    rd(IQ, 8'h01);
    wr(CT, 8'h87);
    repeat (10) @(posedge clk_i);
    wr(CT, 8'h87);
    wait_busy(1'b0);
    check({7'h0, halted_o}, 8'h00);
    rd(IQ, 8'h03);
    for (logic [2:0] s = 1; s < 4; s++)
    begin
      wr(CT, {1'b1, s[1:0], 5'h07});
      repeat (10) @(posedge clk_i);
      wr(CT, {1'b1, s[1:0], 5'h07});
      rd(IQ, 8'h02);
      check({7'h0, halted_o}, 8'h01);
      wr(CT, 8'h00);
      wr(CT, 8'h04);
      wr(CT, 8'h06);
      conv(8'h87, 8'h5A);
      rd(IQ, 8'h01);
    end
    wr(CT, 8'h96);
    timer_trig_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    timer_trig_i <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(RS, 8'h5A);
    rd(IQ, 8'h01);
    wr(CK, 8'h2F);
    wr(CK, 8'h2C);
    rd(ST, 8'h00);
    wr(CK, 8'h0B);
    wr(CK, 8'h08);
    rd(ST, 8'h00);
    wr(CK, 8'h2B);
    wr(CK, 8'h28);
    rd(ST, 8'h04);
    wr(CT, 8'h00);
    wr(CT, 8'h06);
    rd(ST, 8'h04);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(ST, 8'h00);
    end_of_test();
  end
endmodule : acc_ctrl_tb
bind acc_ctrl acc_ctrl_checker acc_ctrl_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_trig_i(timer_trig_i), .async_clk_i(async_clk_i), .analog_i(analog_i),
  .busy_o(busy_o), .halted_o(halted_o), .irq_o(irq_o));
